// [aps_sequencer.sv]
// How it works
// RULE_01: after reset the converter runs its conversions from the externally supplied clock until software selects the internal clock.
// RULE_02: the host's initialisation switches the converter to internal clocking before normal conversions.
// RULE_03: the host writes the acquisition-mode bit as zero unless it wants externally timed acquisition.
// RULE_04: with an external reference the host may convert right after power-up without delay.
// RULE_05: with the internal reference the host waits for the reference to charge at power-up and after full power-down.
// RULE_06: a control write with power code 1,0 and internal acquisition powers up, converts once, then enters standby.
// RULE_07: the completion output goes low when a conversion ends, and the host reads the 16-bit result only after that.
// RULE_08: for full power-down the host writes 1,0, waits for the reference, then writes 1,1 to convert.
// RULE_09: in the shutdown-pin scheme the host raises shutdown, waits, writes 1,0, reads, then lowers shutdown.
// RULE_10: the host starts external acquisition by writing 1,0 with the acquisition-mode bit set, then waits.
// RULE_11: a later write with the acquisition-mode bit clear ends acquisition and starts the conversion.
// RULE_12: for external acquisition with full power-down the host starts conversion with 1,1 and the bit clear.
// RULE_13: the completion output returns high when the result is read or a new control word is written.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module aps_sequencer
  import aps_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic shutdown_n,
  input wire logic ext_conv_tick,
  input wire logic [RESULT_W-1:0] adc_sample,
  output logic [CHAN_W-1:0] channel_sel,
  output logic [4:0] power_state,
  output logic conv_done_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
    reg_hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  aps_state_e state_reg;
  aps_state_e state_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [RESULT_W-1:0] result_reg;
  logic done_n_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_reg;

  // ----------------------------------------------------------------
  // address hits
  // ----------------------------------------------------------------
  wire logic hit_ctrl;
  wire logic hit_result;
  wire logic hit_status;
  wire logic hit_irq_stat;
  wire logic hit_irq_mask;
  wire logic [31:0] status_word;

  assign hit_ctrl = reg_hit(haddr, CTRL_OFF);
  assign hit_result = reg_hit(haddr, RESULT_OFF);
  assign hit_status = reg_hit(haddr, STATUS_OFF);
  assign hit_irq_stat = reg_hit(haddr, IRQ_STAT_OFF);
  assign hit_irq_mask = reg_hit(haddr, IRQ_MASK_OFF);
  assign status_word = {24'h00_0000, state_reg, ~ctrl_reg[INT_CLK_BIT], shutdown_n, done_n_reg}; // RULE_01

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic addr_ph;
  wire logic rd_req;
  wire logic res_rd;
  wire logic ctrl_wr_raw;
  wire logic ctrl_wr;
  wire logic stat_wr;
  wire logic mask_wr;
  wire logic [31:0] rd_mux;

  // single word slave with zero wait states, always OKAY
  assign addr_ph = hsel & htrans[1] & hready;
  assign rd_req = addr_ph & ~hwrite;
  assign res_rd = rd_req & hit_result;
  assign ctrl_wr_raw = wr_pend_reg & reg_hit(wr_addr_reg, CTRL_OFF);
  // control words are ignored while the shutdown pin holds the part off
  assign ctrl_wr = ctrl_wr_raw & shutdown_n;
  assign stat_wr = wr_pend_reg & reg_hit(wr_addr_reg, IRQ_STAT_OFF);
  assign mask_wr = wr_pend_reg & reg_hit(wr_addr_reg, IRQ_MASK_OFF);

  assign rd_mux =
    hit_ctrl ? {24'h00_0000, ctrl_reg} :
    hit_result ? {16'h0000, result_reg} :
    hit_status ? status_word :
    hit_irq_stat ? {30'h0000_0000, irq_stat_reg} :
    hit_irq_mask ? {30'h0000_0000, irq_mask_reg} :
    ZERO_WORD;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  wire logic wr_acq;
  wire logic wr_convert;
  wire logic conv_finish;
  wire logic busy;
  wire logic [1:0] pwr_code;
  wire logic overrun;
  wire logic conv_abort;
  wire logic conv_ext_mode;

  assign wr_acq = ctrl_wr & hwdata[EXT_ACQ_BIT]; // RULE_10
  assign wr_convert = ctrl_wr & ~hwdata[EXT_ACQ_BIT]; // RULE_06 RULE_11
  assign busy = (state_reg == ST_CONV);
  assign overrun = ctrl_wr & busy;
  assign pwr_code = {ctrl_reg[PWR_HI_BIT], ctrl_reg[PWR_LO_BIT]};
  // an acquisition write in mid-conversion stops the timer, so no result lands while acquiring
  assign conv_abort = ~shutdown_n | wr_acq; // RULE_11
  // clock selection comes from the word being written, so the new mode takes effect at once
  assign conv_ext_mode = wr_convert ? ~hwdata[INT_CLK_BIT] : ~ctrl_reg[INT_CLK_BIT]; // RULE_01

  aps_conv_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(wr_convert),
    .abort(conv_abort),
    .ext_mode(conv_ext_mode), // RULE_01
    .ext_tick(ext_conv_tick),
    .finish(conv_finish)
  );

  always_comb begin
    state_next = state_reg;
    if (!shutdown_n) begin
      state_next = ST_SHUT;
    end else if (wr_acq) begin
      state_next = ST_ACQ; // RULE_10
    end else if (wr_convert) begin
      state_next = ST_CONV; // RULE_06 RULE_11
    end else if (conv_finish) begin
      // after the conversion the power code picks the resting state
      unique case (pwr_code)
        PWR_STANDBY: state_next = ST_STBY; // RULE_06
        PWR_FULL_DOWN: state_next = ST_SHUT;
        default: state_next = ST_ON;
      endcase
    end
  end

  assign power_state = state_reg;
  assign channel_sel = ctrl_reg[CHAN_LSB +: CHAN_W];
  assign conv_done_n = done_n_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= ZERO_WORD;
      hrdata_reg <= ZERO_WORD;
    end else begin
      wr_pend_reg <= addr_ph & hwrite;
      wr_addr_reg <= haddr;
      hrdata_reg <= rd_req ? rd_mux : ZERO_WORD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_STBY;
      ctrl_reg <= CTRL_RESET; // RULE_01
      irq_mask_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (ctrl_wr) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
      if (mask_wr) begin
        irq_mask_reg <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // a finishing conversion wins over a result read in the same cycle; a control write in that cycle cancels the finish
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_n_reg <= 1'b1;
      result_reg <= '0;
    end else if (conv_finish) begin
      done_n_reg <= 1'b0; // RULE_07
      result_reg <= adc_sample; // RULE_07
    end else if (res_rd || ctrl_wr) begin
      done_n_reg <= 1'b1; // RULE_13
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(stat_wr ? hwdata[IRQ_W-1:0] : 2'h0))
                    | {overrun, conv_finish};
    end
  end

endmodule : aps_sequencer
`default_nettype wire

// [aps_pkg.sv]
package aps_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] RESULT_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  localparam int INT_CLK_BIT = 4;
  localparam int EXT_ACQ_BIT = 5;
  localparam int PWR_LO_BIT = 6;
  localparam int PWR_HI_BIT = 7;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [1:0] PWR_FULL_DOWN = 2'h3;

  // ----------------------------------------------------------------
  // status and interrupt fields
  // ----------------------------------------------------------------
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int RESULT_W = 16;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_CONV_TICKS = 16;
  localparam int CNT_W = 8;

  typedef enum logic [4:0] {
    ST_SHUT = 5'h01,
    ST_STBY = 5'h02,
    ST_ON = 5'h04,
    ST_ACQ = 5'h08,
    ST_CONV = 5'h10
  } aps_state_e;

endpackage : aps_pkg

// [aps_conv_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module aps_conv_timer
  import aps_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic abort,
  input wire logic ext_mode,
  input wire logic ext_tick,
  output logic finish
);

  logic running_reg;
  logic [CNT_W-1:0] cnt_reg;
  wire logic step;
  wire logic last;
  wire logic [CNT_W-1:0] target;

  // external clock mode advances only on externally supplied ticks
  assign step = ext_mode ? ext_tick : 1'b1;
  assign target = ext_mode ? CNT_W'(EXT_CONV_TICKS - 1) : CNT_W'(CONV_CYCLES - 1);
  assign last = (cnt_reg == target);
  assign finish = running_reg & step & last & ~start & ~abort;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (start) begin
      running_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (abort || finish) begin
      running_reg <= 1'b0;
    end else if (running_reg && step) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

endmodule : aps_conv_timer
`default_nettype wire

// [aps_front_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external conversion clock source
// ----------------------------------------
module aps_front_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick_en,
  output logic ext_conv_tick
);
  logic [1:0] div_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_reg <= 2'h0;
    else div_reg <= div_reg + 2'h1;
  end
  // ticks once every four clocks while tick_en is high, and stands still while the bench holds tick_en low
  assign ext_conv_tick = tick_en && div_reg == 2'h3;
endmodule : aps_front_model
`default_nettype wire

// [aps_sequencer_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module aps_sequencer_checker (
  input wire logic hclk, input wire logic hresetn, input wire logic hsel, input wire logic [31:0] haddr,
  input wire logic [1:0] htrans, input wire logic hwrite, input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata, input wire logic hready, input wire logic hreadyout, input wire logic hresp,
  input wire logic [31:0] hrdata, input wire logic shutdown_n, input wire logic ext_conv_tick,
  input wire logic [15:0] adc_sample, input wire logic [2:0] channel_sel, input wire logic [4:0] power_state,
  input wire logic conv_done_n, input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic req = hsel && htrans[1] && hready;
  logic rd_reg, cw_reg;
  logic [1:0] pc_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
      cw_reg <= 1'b0;
      pc_reg <= 2'h0;
    end else begin
      rd_reg <= req && !hwrite;
      cw_reg <= req && hwrite && haddr == 32'h0000_0000;
      if (cw_reg && shutdown_n) pc_reg <= hwdata[7:6];
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  rd_idle_a: assert property (!rd_reg |-> hrdata == 32'h0000_0000) else $error("read data outside data phase");
  conv_end_a: assert property ($fell(conv_done_n) |-> $past(power_state) == 5'h10) else $error("done without conversion");
  end_state_a: assert property ($fell(conv_done_n) |-> power_state == (pc_reg == 2'h2 ? 5'h02 :
    pc_reg == 2'h3 ? 5'h01 : 5'h04)) else $error("wrong state after conversion");
  acq_idle_a: assert property (power_state == 5'h08 |-> conv_done_n) else $error("done low while acquiring");
  acq_conv_a: assert property (cw_reg && shutdown_n && !hwdata[5] |=> power_state == 5'h10) else $error("no conversion start");
  wr_clear_a: assert property (cw_reg && shutdown_n |=> conv_done_n) else $error("done not cleared by write");
  rd_clear_a: assert property (req && !hwrite && haddr == 32'h0000_0004 && power_state != 5'h10 |=> conv_done_n)
    else $error("done not cleared by read");
  shut_state_a: assert property (!shutdown_n |=> power_state == 5'h01) else $error("shutdown not honoured");
  cover property ($fell(conv_done_n));
  cover property (power_state == 5'h08);
  cover property (irq);
endmodule : aps_sequencer_checker
bind aps_sequencer aps_sequencer_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .shutdown_n(shutdown_n), .ext_conv_tick(ext_conv_tick), .adc_sample(adc_sample),
  .channel_sel(channel_sel), .power_state(power_state), .conv_done_n(conv_done_n), .irq(irq));
`default_nettype wire

// [adc_power_acq_sequencer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module adc_power_acq_sequencer_bench;
  import aps_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, shutdown_n = 1, tick_en = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, chan;
  logic [7:0] c;
  logic [15:0] sample = 0;
  wire logic hready, hresp, conv_done_n, irq, tick;
  wire logic [31:0] hrdata;
  wire logic [2:0] channel_sel;
  wire logic [4:0] power_state;
  int errors = 0, cmp_count = 0, seed = 87, n;
  aps_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .shutdown_n(shutdown_n), .ext_conv_tick(tick), .adc_sample(sample), .channel_sel(channel_sel),
    .power_state(power_state), .conv_done_n(conv_done_n), .irq(irq));
  aps_front_model fm (.hclk(hclk), .hresetn(hresetn), .tick_en(tick_en), .ext_conv_tick(tick));
  function automatic logic [31:0] end_state(input logic [1:0] pc);
    return pc == 2'h2 ? 32'h0000_0002 : pc == 2'h3 ? 32'h0000_0001 : 32'h0000_0004;
  endfunction : end_state
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : xfer
  task automatic wait_done(output int k);
    k = 0;
    while (conv_done_n !== 1'b0 && k < 400) begin
      @(posedge hclk);
      #1;
      k++;
    end
  endtask : wait_done
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial forever #5 hclk = ~hclk;
  // whole run is under 2000 cycles; 30000 cycles before giving up
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(STATUS_OFF, 1'b0, 0);
    chk(rd, 32'h0000_0017);
    xfer(32'h0000_0040, 1'b0, 0);
    chk(rd, 32'h0000_0000);
    xfer(CTRL_OFF, 1'b1, 32'h0000_0080);
    repeat (150) @(posedge hclk);
    chk(conv_done_n, 1);
    tick_en <= 1'b1;
    wait_done(n);
    chk(power_state, 32'h0000_0002);
    @(posedge hclk);
    tick_en <= 1'b0;
    $display("external clock test done");
    xfer(IRQ_MASK_OFF, 1'b1, 32'h0000_0001);
    xfer(IRQ_STAT_OFF, 1'b1, 32'h0000_0003);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      sample <= 16'($random(seed));
      chan = 3'($random(seed));
      c = {i[1:0], 1'b0, 1'b1, 1'b0, chan};
      if (i > 3) begin
        xfer(CTRL_OFF, 1'b1, {24'h0, c | 8'h20});
        chk(power_state, 32'h0000_0008);
        repeat (120) @(posedge hclk);
        chk(conv_done_n, 1);
      end
      xfer(CTRL_OFF, 1'b1, {24'h0, c});
      wait_done(n);
      chk(n, CONV_CYCLES);
      chk(power_state, end_state(i[1:0]));
      chk(channel_sel, chan);
      chk(irq, 1);
      xfer(RESULT_OFF, 1'b0, 0);
      chk(rd, {16'h0, sample});
      chk(conv_done_n, 1);
      xfer(IRQ_STAT_OFF, 1'b1, 32'h0000_0001);
      chk(irq, 0);
    end
    $display("power code test done");
    xfer(CTRL_OFF, 1'b1, 32'h0000_0090);
    xfer(CTRL_OFF, 1'b1, 32'h0000_0090);
    wait_done(n);
    chk(n, CONV_CYCLES);
    xfer(IRQ_STAT_OFF, 1'b0, 0);
    chk(rd, 32'h0000_0003);
    xfer(IRQ_MASK_OFF, 1'b1, 32'h0000_0000);
    chk(irq, 0);
    xfer(IRQ_STAT_OFF, 1'b1, 32'h0000_0003);
    $display("overrun test done");
    @(posedge hclk);
    shutdown_n <= 1'b0;
    xfer(CTRL_OFF, 1'b1, 32'h0000_0097);
    chk(power_state, 32'h0000_0001);
    xfer(CTRL_OFF, 1'b0, 0);
    chk(rd, 32'h0000_0090);
    @(posedge hclk);
    shutdown_n <= 1'b1;
    repeat (50) @(posedge hclk);
    xfer(CTRL_OFF, 1'b1, 32'h0000_0090);
    wait_done(n);
    chk(n, CONV_CYCLES);
    xfer(RESULT_OFF, 1'b0, 0);
    chk(rd, {16'h0, sample});
    $display("shutdown test done");
    tally_and_finish();
  end
endmodule : adc_power_acq_sequencer_bench
`default_nettype wire
